// File: lan_wake_fc_sva.sv
`timescale 1ns/1ns
`default_nettype none
module lan_wake_fc_sva
  import lan_wake_pkg::*;
#(
  parameter int FREE_W = 13
)(
  input  wire logic              i_clock,
  input  wire logic              i_srst,
  input  wire logic              i_ce,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [31:0]       o_prdata,
  input  wire logic              i_link_up,
  input  wire logic              i_wake_frame,
  input  wire logic              i_filter_match,
  input  wire logic [FREE_W-1:0] i_rx_free,
  input  wire logic              o_pause_req,
  input  wire logic              o_pme_status,
  input  wire logic              o_pme
);
  // ----
  // Write strobes and threshold shadow
  // ----
  wire logic  wr = i_psel & i_penable & i_pwrite & i_ce;
  wire logic  ws = wr && i_paddr == 12'h06c;
  logic [2:0] thr_q;
  int         thr_b;
  always_ff @(posedge i_clock)
    thr_q <= i_srst ? 3'h0 : (wr && i_paddr == 12'h068) ? i_pwdata[2:0] : thr_q;
  // Free bytes for the current code
  always_comb thr_b = (thr_q == 3'h0) ? 512 : 768 + 256 * int'(thr_q);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  AST_WAKE_FRAME: assert property (i_ce && i_wake_frame |=> o_pme_status)
    else $error("wake frame left pme status low");
  AST_LINK_CHG: assert property (i_ce && !$past(i_srst) && $changed(i_link_up) |=> o_pme_status)
    else $error("link change left pme status low");
  AST_FILTER: assert property (i_ce && i_filter_match |=> o_pme_status)
    else $error("filter match left pme status low");
  AST_PME_GATE: assert property (o_pme |-> o_pme_status)
    else $error("pme high without status");
  AST_PME_CLR: assert property (ws && i_pwdata[0] && !i_wake_frame && !i_filter_match
    && !$changed(i_link_up) |=> !o_pme_status ##1 !o_pme)
    else $error("pme clear failed");
  AST_ZERO_KEEP: assert property (ws && !i_pwdata[0] && o_pme_status |=> o_pme_status)
    else $error("zero write cleared pme status");
  AST_STICKY: assert property (o_pme_status && !ws |=> o_pme_status)
    else $error("pme status dropped without write");
  AST_RSVD: assert property (i_psel && i_penable && !i_pwrite && i_paddr == 12'h06c |-> o_prdata[4:1] == 4'h0)
    else $error("reserved bits read nonzero");
  AST_PAUSE: assert property (i_ce && !$past(i_srst) && i_rx_free <= thr_b
    && $past(i_rx_free) > thr_b |-> ##[1:2] o_pause_req)
    else $error("no pause pulse at threshold");

  // Main scenarios reached
  cover property (ws && i_pwdata[0] && o_pme_status);
  cover property (o_pause_req);
  cover property (o_pme);
endmodule

bind lan_wake_fc_top lan_wake_fc_sva #(.FREE_W(FREE_W)) lan_wake_fc_sva_inst (
  .i_clock, .i_srst, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .o_prdata, .i_link_up, .i_wake_frame, .i_filter_match, .i_rx_free, .o_pause_req,
  .o_pme_status, .o_pme
);
`default_nettype wire

// File: lan_wake_fc_top.sv
// Summary of operation
// - Send a pause frame when receive FIFO free space falls to threshold.
// - Code 0 is 0.50 KB, code 1 is 1.00 KB, then 0.25 KB steps.
// - Link status change sets the link change flag.
// - Writing one clears a wake status flag.
// - Wake frame flag sets regardless of wake or PME enables.
// - Filter-matching received packet sets the interesting packet flag.
// - PME status flag mirrors the power management PME status bit.
// - Clearing PME status also clears the PM bit and drops PME.
// - Any wake-up event sets PME status, whatever PME enable says.
// - Wake status register is 8 bits, zero after reset.
`timescale 1ns/1ns
`default_nettype none
module lan_wake_fc_top
  import lan_wake_pkg::*;
#(
  parameter int FREE_W = 13
)(
  input  wire logic              i_clock,
  input  wire logic              i_srst,
  input  wire logic              i_ce,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_link_up,
  input  wire logic              i_wake_frame,
  input  wire logic              i_filter_match,
  input  wire logic [FREE_W-1:0] i_rx_free,
  output logic                   o_pause_req,
  output logic                   o_pme_status,
  output logic                   o_pme,
  output logic                   o_irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]       thresh;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic             pme_en;
    logic             pme_st;
    logic             link_q;
    logic             link_seen;
    logic [31:0]      rdata;
    logic             slverr;
  } st_t;
  st_t s_q, s_d;

  logic       pause;
  logic       pme_clr;
  logic       ws_wr;
  logic       wr;
  logic       rd;
  logic [9:0] idx;
  logic       link_chg;
  logic       wake_ev;

  wake_evt_if evt ();

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [9:0] a);
    mapped = (a == 10'(IDX_FC_THRESH)) || (a == 10'(IDX_WAKE_STATUS)) ||
             (a == 10'(IDX_IRQ_STATUS)) || (a == 10'(IDX_IRQ_MASK)) ||
             (a == 10'(IDX_PM_CTRL)) || (a == 10'(IDX_RX_FREE));
  endfunction

  // Write strobe in access phase, read strobe in setup phase, one cycle answer
  assign idx   = i_paddr[ADDR_W-1:2];
  assign wr    = i_psel && i_penable && i_pwrite && i_ce;
  assign rd    = i_psel && !i_penable && !i_pwrite;
  assign ws_wr = wr && (idx == 10'(IDX_WAKE_STATUS));

  // Events from pin-side logic on this clock
  assign link_chg = s_q.link_seen && (i_link_up != s_q.link_q);
  assign wake_ev  = link_chg || i_wake_frame || i_filter_match;

  assign evt.link_chg    = link_chg;
  assign evt.wake_frame  = i_wake_frame;
  assign evt.interesting = i_filter_match;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  pause_trigger #(
    .FREE_W  (FREE_W)
  ) u_pause (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_ce    (i_ce),
    .i_code  (s_q.thresh),
    .i_free  (i_rx_free),
    .o_pause (pause)
  );

  wake_status_reg u_ws (
    .i_clock      (i_clock),
    .i_srst       (i_srst),
    .i_ce         (i_ce),
    .evt          (evt),
    .i_wake_event (wake_ev),
    .i_wr         (ws_wr),
    .i_wdata      (i_pwdata[7:0]),
    .o_pme_clr    (pme_clr)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.link_q    = i_link_up;
    s_d.link_seen = 1'b1;
    // Register writes
    if (wr)
    begin
      unique case (idx)
        10'(IDX_FC_THRESH):  s_d.thresh   = i_pwdata[2:0];
        10'(IDX_IRQ_MASK):   s_d.irq_mask = i_pwdata[IRQ_W-1:0];
        10'(IDX_IRQ_STATUS): s_d.irq_st   = s_q.irq_st & ~i_pwdata[IRQ_W-1:0];
        10'(IDX_PM_CTRL):    s_d.pme_en   = i_pwdata[PM_PME_EN];
        default:             s_d.thresh   = s_q.thresh;
      endcase
    end
    // PM status bit, cleared through the wake status register
    if (wr && idx == 10'(IDX_WAKE_STATUS) && i_pwdata[WS_PME_STATUS])
      s_d.pme_st = 1'b0;
    if (wake_ev)
      s_d.pme_st = 1'b1;
    // Sticky interrupt events, set wins
    if (link_chg)
      s_d.irq_st[WS_LINK_CHG - 7] = 1'b1;
    if (i_wake_frame)
      s_d.irq_st[1] = 1'b1;
    if (i_filter_match)
      s_d.irq_st[2] = 1'b1;
    if (pause)
      s_d.irq_st[IRQ_PAUSE] = 1'b1;
    // Read data captured in setup, presented in access
    // Answer held through access so it is stable at the pready edge
    if (i_psel && !i_penable)
      s_d.slverr = !mapped(idx);
    if (rd)
    begin
      unique case (idx)
        10'(IDX_FC_THRESH):   s_d.rdata = {29'h0, s_q.thresh};
        10'(IDX_WAKE_STATUS): s_d.rdata = {24'h0, evt.status};
        10'(IDX_IRQ_STATUS):  s_d.rdata = {28'h0, s_q.irq_st};
        10'(IDX_IRQ_MASK):    s_d.rdata = {28'h0, s_q.irq_mask};
        10'(IDX_PM_CTRL):     s_d.rdata = {30'h0, s_q.pme_st, s_q.pme_en};
        10'(IDX_RX_FREE):     s_d.rdata = 32'(i_rx_free);
        default:              s_d.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      s_q           <= '0;
      s_q.thresh    <= FC_THRESH_RESET;
      s_q.irq_st    <= IRQ_RESET;
      s_q.irq_mask  <= IRQ_RESET;
    end
    else if (i_ce)
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_pready     = i_ce;
  assign o_prdata     = s_q.rdata;
  assign o_pslverr    = s_q.slverr && i_psel && i_penable;
  assign o_pause_req  = pause;
  assign o_pme_status = s_q.pme_st;
  assign o_pme        = s_q.pme_st && s_q.pme_en && !pme_clr;
  assign o_irq        = |(s_q.irq_st & s_q.irq_mask);
endmodule
`default_nettype wire

// File: lan_wake_pkg.sv
package lan_wake_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses = 4 x index)
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_FC_THRESH     = 8'h1a;
  localparam logic [7:0]  IDX_WAKE_STATUS   = 8'h1b;
  localparam logic [7:0]  IDX_IRQ_STATUS    = 8'h40;
  localparam logic [7:0]  IDX_IRQ_MASK      = 8'h41;
  localparam logic [7:0]  IDX_PM_CTRL       = 8'h42;
  localparam logic [7:0]  IDX_RX_FREE       = 8'h43;
  localparam int          ADDR_W            = 12;

  // ----------------------------------------------------------------
  // Wake status field positions
  // ----------------------------------------------------------------
  localparam int          WS_LINK_CHG       = 7;
  localparam int          WS_WAKE_FRAME     = 6;
  localparam int          WS_INTERESTING    = 5;
  localparam int          WS_PME_STATUS     = 0;
  localparam logic [7:0]  WS_IMPL_MASK      = 8'he1;
  localparam logic [7:0]  WS_RESET          = 8'h00;

  // ----------------------------------------------------------------
  // Threshold field and table (free bytes)
  // ----------------------------------------------------------------
  localparam logic [2:0]  FC_THRESH_RESET   = 3'h0;
  localparam int          FC_BASE_BYTES     = 512;
  localparam int          FC_CODE1_BYTES    = 1024;
  localparam int          FC_STEP_BYTES     = 256;

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  localparam int          IRQ_W             = 4;
  localparam int          IRQ_PAUSE         = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET    = 4'h0;

  // ----------------------------------------------------------------
  // PM control bits
  // ----------------------------------------------------------------
  localparam int          PM_PME_EN         = 0;

endpackage

// File: pause_trigger.sv
`timescale 1ns/1ns
`default_nettype none
module pause_trigger
  import lan_wake_pkg::*;
#(
  parameter int FREE_W = 13
)(
  input  wire logic              i_clock,
  input  wire logic              i_srst,
  input  wire logic              i_ce,
  input  wire logic [2:0]        i_code,
  input  wire logic [FREE_W-1:0] i_free,
  output logic                   o_pause
);
  initial if (FREE_W < 12) $error("FREE_W too small for 2.5 KB");

  typedef struct packed { logic below; logic pulse; } st_t;
  st_t s_q, s_d;

  // Threshold bytes for a code
  function automatic logic [FREE_W-1:0] thresh(input logic [2:0] c);
    if (c == 3'h0)
      thresh = FREE_W'(FC_BASE_BYTES);
    else
      thresh = FREE_W'(FC_CODE1_BYTES + (int'(c) - 1) * FC_STEP_BYTES);
  endfunction

  // Pulse once as free space falls to the threshold
  always_comb
  begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (i_free <= thresh(i_code))
    begin
      if (!s_q.below)
        s_d.pulse = 1'b1;
      s_d.below = 1'b1;
    end
    else
      s_d.below = 1'b0;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      s_q <= '0;
    else if (i_ce)
      s_q <= s_d;
  end

  assign o_pause = s_q.pulse;
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lan_wake_pkg::*;
  logic              i_clock = 1'h0, i_srst = 1'h1, i_ce = 1'h1;
  logic              i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
  logic [ADDR_W-1:0] i_paddr = 12'h000;
  logic [31:0]       i_pwdata = 32'h0, o_prdata, rdata;
  logic              o_pready, o_pslverr, serr;
  logic              i_link_up = 1'h0, i_wake_frame = 1'h0, i_filter_match = 1'h0;
  logic [12:0]       i_rx_free = 13'h1fff;
  logic              o_pause_req, o_pme_status, o_pme, o_irq;
  int                err_count = 0, n_tests = 0, pulses = 0;

  lan_wake_fc_top #(.FREE_W(13)) lan_wake_fc_top_inst (
    .i_clock, .i_srst, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_link_up, .i_wake_frame,
    .i_filter_match, .i_rx_free, .o_pause_req, .o_pme_status, .o_pme, .o_irq
  );

  // ----
  // Clock, pulse count, helpers
  // ----
  initial forever #5 i_clock = ~i_clock;
  always @(posedge i_clock) if (o_pause_req) pulses++;

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'h1;
    do @(posedge i_clock); while (o_pready !== 1'h1);
    rdata = o_prdata;
    serr = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, rdata, e);
  endtask

  // Event 0 link toggle, 1 wake frame, 2 filter match
  task automatic pulse(input int k);
    @(posedge i_clock);
    if (k == 0) i_link_up <= ~i_link_up;
    if (k == 1) i_wake_frame <= 1'h1;
    if (k == 2) i_filter_match <= 1'h1;
    @(posedge i_clock);
    i_wake_frame <= 1'h0;
    i_filter_match <= 1'h0;
    @(posedge i_clock);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    rchk("wake_st", 12'h06c, 32'h0);
    rchk("thresh", 12'h068, 32'h0);
    rchk("unmapped", 12'h200, 32'h0);
    chk("slverr", serr, 32'h1);
    chk("pme_rst", {o_pme_status, o_pme}, 32'h0);
  endtask

  task automatic t_events;
    logic [31:0] e;
    for (int k = 0; k < 3; k++)
    begin
      e = 32'h01 | (32'h80 >> k);
      pulse(k);
      rchk("flags", 12'h06c, e);
      chk("pme_off", o_pme, 32'h0);
      apb(1'h1, 12'h06c, 32'h0);
      rchk("zero_wr", 12'h06c, e);
      apb(1'h1, 12'h06c, 32'hff);
      rchk("cleared", 12'h06c, 32'h0);
    end
  endtask

  task automatic t_pme;
    apb(1'h1, 12'h108, 32'h1);
    pulse(1);
    chk("pme_on", {o_pme_status, o_pme}, 32'h3);
    rchk("pm_ctrl", 12'h108, 32'h3);
    apb(1'h1, 12'h06c, 32'hfe);
    rchk("keep", 12'h06c, 32'h01);
    apb(1'h1, 12'h06c, 32'h01);
    @(posedge i_clock);
    chk("pme_clr", {o_pme_status, o_pme}, 32'h0);
    rchk("pm_clr", 12'h108, 32'h1);
    apb(1'h1, 12'h108, 32'h0);
  endtask

  task automatic t_irq;
    apb(1'h1, 12'h100, 32'hf);
    apb(1'h1, 12'h104, 32'h2);
    pulse(2);
    chk("irq_mask", o_irq, 32'h0);
    pulse(1);
    chk("irq_on", o_irq, 32'h1);
    rchk("irq_st", 12'h100, 32'h6);
    apb(1'h1, 12'h100, 32'h2);
    rchk("irq_st2", 12'h100, 32'h4);
    chk("irq_off", o_irq, 32'h0);
  endtask

  task automatic t_pause;
    int thr;
    int p0;
    for (int c = 0; c < 8; c++)
    begin
      thr = (c == 0) ? 512 : 768 + 256 * c;
      apb(1'h1, 12'h068, 32'(c));
      rchk("thresh", 12'h068, 32'(c));
      i_rx_free <= 13'h1fff;
      repeat (4) @(posedge i_clock);
      p0 = pulses;
      i_rx_free <= 13'(thr + 1);
      repeat (4) @(posedge i_clock);
      i_rx_free <= 13'(thr);
      repeat (4) @(posedge i_clock);
      chk("pause", 32'(pulses - p0), 32'h1);
    end
  endtask

  // ----
  // Verdict, main sequence, watchdog
  // ----
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge i_clock);
    i_srst <= 1'h0;
    t_reset;
    t_events;
    t_pme;
    t_irq;
    t_pause;
    wrap_up;
  end

  initial
  begin
    repeat (5000) @(posedge i_clock);
    err_count++;
    wrap_up;
  end
endmodule
`default_nettype wire

// File: wake_evt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface wake_evt_if;
  logic       link_chg;
  logic       wake_frame;
  logic       interesting;
  logic [7:0] status;

  modport src  (output link_chg, output wake_frame, output interesting, input status);
  modport sink (input link_chg, input wake_frame, input interesting, output status);
endinterface
`default_nettype wire

// File: wake_status_reg.sv
`timescale 1ns/1ns
`default_nettype none
module wake_status_reg
  import lan_wake_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_srst,
  input  wire logic       i_ce,
  wake_evt_if.sink        evt,
  input  wire logic       i_wake_event,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  output logic            o_pme_clr
);
  typedef struct packed { logic [7:0] ws; logic clr; } st_t;
  st_t s_q, s_d;

  // Write-one-to-clear, set wins over clear
  always_comb
  begin
    s_d = s_q;
    s_d.clr = 1'b0;
    if (i_wr)
    begin
      s_d.ws = s_q.ws & ~(i_wdata & WS_IMPL_MASK);
      s_d.clr = i_wdata[WS_PME_STATUS];
    end
    if (evt.link_chg)
      s_d.ws[WS_LINK_CHG] = 1'b1;
    if (evt.wake_frame)
      s_d.ws[WS_WAKE_FRAME] = 1'b1;
    if (evt.interesting)
      s_d.ws[WS_INTERESTING] = 1'b1;
    if (i_wake_event)
    begin
      s_d.ws[WS_PME_STATUS] = 1'b1;
      s_d.clr = 1'b0;
    end
    s_d.ws = s_d.ws & WS_IMPL_MASK;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      s_q <= '{ws: WS_RESET, clr: 1'b0};
    else if (i_ce)
      s_q <= s_d;
  end

  assign evt.status = s_q.ws;
  assign o_pme_clr  = s_q.clr;
endmodule
`default_nettype wire
